// ---- ord_params.svh ----
// Constants for the output routing and driver control register bank.
`ifndef ORD_PARAMS_SVH
`define ORD_PARAMS_SVH

// Register offsets on the control port.
`define ORD_ADDR_SPK_AMP   7'h20
`define ORD_ADDR_ROUTING   7'h23
`define ORD_ADDR_VOL_LP    7'h24
`define ORD_ADDR_VOL_RP    7'h25
`define ORD_ADDR_VOL_SPK   7'h26
`define ORD_ADDR_RSVD_A    7'h27
`define ORD_ADDR_DRV_LP    7'h28
`define ORD_ADDR_DRV_RP    7'h29
`define ORD_ADDR_DRV_SPK   7'h2a
`define ORD_ADDR_RSVD_B    7'h2b

// Reset values.
`define ORD_RST_SPK_AMP    8'h06
`define ORD_RST_ROUTING    8'h00
`define ORD_RST_VOL        8'h7f
`define ORD_RST_DRV_HP     8'h02
`define ORD_RST_DRV_SPK    8'h00
`define ORD_RST_RSVD_A     8'h7f
`define ORD_RST_RSVD_B     8'h00

// Mask that keeps the read-only status bit out of stored writes.
`define ORD_WMASK_STATUS   8'hfe

// Field positions.
`define ORD_LDAC_HI        7
`define ORD_LDAC_LO        6
`define ORD_ANALOG_INPUT_ONE_LEFT      5
`define ORD_ANALOG_INPUT_TWO_LEFT      4
`define ORD_RDAC_HI        3
`define ORD_RDAC_LO        2
`define ORD_ANALOG_INPUT_TWO_RIGHT     1
`define ORD_DIFF           0
`define ORD_VOL_ROUTE      7
`define ORD_VOL_HI         6
`define ORD_VOL_LO         0
`define ORD_PGAIN_HI       6
`define ORD_PGAIN_LO       3
`define ORD_SGAIN_HI       4
`define ORD_SGAIN_LO       3
`define ORD_UNMUTE         2
`define ORD_PD_HIZ         1
`define ORD_SPK_POWER      7

// Field codes.
`define ORD_ROUTE_MIXER    2'b01
`define ORD_ROUTE_PHONE    2'b10
`define ORD_PGAIN_MAX      4'h9

// Channel indices: left phone, right phone, speaker.
`define ORD_CH_LP          0
`define ORD_CH_RP          1
`define ORD_CH_SPK         2
`define ORD_CHANNELS       3

// Gain stepping period.
`define ORD_STEP_NS        1000
`define ORD_CLK_NS         8
`define ORD_STEP_CYCLES    ((`ORD_STEP_NS + `ORD_CLK_NS - 1) / `ORD_CLK_NS)

`endif

// ---- ord_pkg.sv ----
// Types shared by the output routing and driver control register bank.
package ord_pkg;
	typedef logic [7:0] ord_byte_t;	// One register byte.
	typedef logic [6:0] ord_vol_t;	// Analog volume code.
	typedef logic [3:0] ord_gain_t;	// Driver gain code.
endpackage

// ---- ord_output_routing_driver_regs.sv ----
// Output routing, volume routing and driver gain register bank.
`timescale 1ns/10ps
`include "ord_params.svh"

// Behaviour
// - Left converter field: none, mixer, phone driver.
// - Bit 5 routes input one to left mixer.
// - Bit 4 routes input two to left mixer.
// - Right converter field: none, mixer, phone driver.
// - Bit 1 routes input two to right mixer.
// - Bit 0 feeds left driver into right driver.
// - Phone volume bit 7 connects volume to driver.
// - Seven-bit volume codes reset to all ones.
// - Speaker volume bit 7 connects left volume.
// - Left phone gain 0 to 9 dB.
// - Right phone gain 0 to 9 dB.
// - Phone bit 2 unmutes; reset leaves muted.
// - Phone bit 1 selects high-impedance power-down.
// - Left phone done flag when gains applied.
// - Right phone done flag when gains applied.
// - Speaker gain codes give 6 to 24 dB.
// - Speaker bit 2 unmutes; reset leaves muted.
// - Speaker done flag when gains applied.
// - Amplifier bit 7 powers speaker driver up.
module ord_output_routing_driver_regs #(
	parameter int STEP_CYCLES = `ORD_STEP_CYCLES	// Cycles per gain step.
) (
	input  wire logic                 clock,
	input  wire logic                 reset_n,
	input  wire logic                 clk_en,
	input  wire logic                 reg_write,
	input  wire logic [6:0]           reg_addr,
	input  wire ord_pkg::ord_byte_t   reg_wdata,
	output ord_pkg::ord_byte_t        reg_rdata,
	output logic                      left_dac_to_mixer,
	output logic                      left_dac_to_phone,
	output logic                      ain_one_to_left_mixer,
	output logic                      ain_two_to_left_mixer,
	output logic                      right_dac_to_mixer,
	output logic                      right_dac_to_phone,
	output logic                      ain_two_to_right_mixer,
	output logic                      left_to_right_phone,
	output logic [2:0]                volume_route,
	output ord_pkg::ord_vol_t [2:0]   applied_volume,
	output ord_pkg::ord_gain_t [2:0]  applied_gain,
	output logic [2:0]                driver_unmute,
	output logic [1:0]                phone_pd_hiz,
	output logic                      speaker_power_up,
	output logic [2:0]                gain_done
);
	localparam int CW = $clog2(STEP_CYCLES);	// Step counter width.

	// Refuse a step period that the counter cannot serve.
	if (STEP_CYCLES < 2) begin : g_check
		$error("STEP_CYCLES must be at least 2");
	end

	ord_pkg::ord_byte_t        routing;		// Mixer routing register.
	ord_pkg::ord_byte_t        spk_amp;		// Speaker amplifier control.
	ord_pkg::ord_byte_t [2:0]  vol;		// Volume registers.
	ord_pkg::ord_byte_t [2:0]  drv;		// Driver registers.
	logic [CW-1:0]             step_cnt;		// Gain step timer.
	ord_pkg::ord_byte_t        next_routing;
	ord_pkg::ord_byte_t        next_spk_amp;
	ord_pkg::ord_byte_t [2:0]  next_vol;
	ord_pkg::ord_byte_t [2:0]  next_drv;
	ord_pkg::ord_byte_t        next_rdata;
	logic [CW-1:0]             next_step_cnt;
	logic                      step_tick;		// One step of every ramp.
	logic [7:0]                next_route_flags;	// Decoded routing.
	logic [2:0]                next_volume_route;
	logic [2:0]                next_unmute;
	logic [1:0]                next_hiz;

	// Register writes, read mux and decoded control outputs.
	always_comb begin
		next_routing = routing;
		next_spk_amp = spk_amp;
		next_vol = vol;
		next_drv = drv;
		// Writes land only on the writable registers.
		if (reg_write) begin
			if (reg_addr == `ORD_ADDR_ROUTING) begin
				next_routing = reg_wdata;
			end else if (reg_addr == `ORD_ADDR_SPK_AMP) begin
				next_spk_amp = reg_wdata & `ORD_WMASK_STATUS;
			end else if (reg_addr == `ORD_ADDR_VOL_LP) begin
				next_vol[`ORD_CH_LP] = reg_wdata;
			end else if (reg_addr == `ORD_ADDR_VOL_RP) begin
				next_vol[`ORD_CH_RP] = reg_wdata;
			end else if (reg_addr == `ORD_ADDR_VOL_SPK) begin
				next_vol[`ORD_CH_SPK] = reg_wdata;
			end else if (reg_addr == `ORD_ADDR_DRV_LP) begin
				next_drv[`ORD_CH_LP] = reg_wdata & `ORD_WMASK_STATUS;
			end else if (reg_addr == `ORD_ADDR_DRV_RP) begin
				next_drv[`ORD_CH_RP] = reg_wdata & `ORD_WMASK_STATUS;
			end else if (reg_addr == `ORD_ADDR_DRV_SPK) begin
				next_drv[`ORD_CH_SPK] = reg_wdata & `ORD_WMASK_STATUS;
			end
		end
		// Read data shows stored fields plus the live done flags.
		next_rdata = 8'h00;
		if (reg_addr == `ORD_ADDR_ROUTING) begin
			next_rdata = routing;
		end else if (reg_addr == `ORD_ADDR_SPK_AMP) begin
			next_rdata = spk_amp;
		end else if (reg_addr == `ORD_ADDR_VOL_LP) begin
			next_rdata = vol[`ORD_CH_LP];
		end else if (reg_addr == `ORD_ADDR_VOL_RP) begin
			next_rdata = vol[`ORD_CH_RP];
		end else if (reg_addr == `ORD_ADDR_VOL_SPK) begin
			next_rdata = vol[`ORD_CH_SPK];
		end else if (reg_addr == `ORD_ADDR_RSVD_A) begin
			next_rdata = `ORD_RST_RSVD_A;
		end else if (reg_addr == `ORD_ADDR_DRV_LP) begin
			next_rdata = {drv[`ORD_CH_LP][7:1], gain_done[`ORD_CH_LP]};
		end else if (reg_addr == `ORD_ADDR_DRV_RP) begin
			next_rdata = {drv[`ORD_CH_RP][7:1], gain_done[`ORD_CH_RP]};
		end else if (reg_addr == `ORD_ADDR_DRV_SPK) begin
			next_rdata = {drv[`ORD_CH_SPK][7:1], gain_done[`ORD_CH_SPK]};
		end else if (reg_addr == `ORD_ADDR_RSVD_B) begin
			next_rdata = `ORD_RST_RSVD_B;
		end
		// Reserved routing code 11 connects nothing.
		next_route_flags[0] = next_routing[`ORD_LDAC_HI:`ORD_LDAC_LO]
			== `ORD_ROUTE_MIXER;
		next_route_flags[1] = next_routing[`ORD_LDAC_HI:`ORD_LDAC_LO]
			== `ORD_ROUTE_PHONE;
		next_route_flags[2] = next_routing[`ORD_ANALOG_INPUT_ONE_LEFT];
		next_route_flags[3] = next_routing[`ORD_ANALOG_INPUT_TWO_LEFT];
		next_route_flags[4] = next_routing[`ORD_RDAC_HI:`ORD_RDAC_LO]
			== `ORD_ROUTE_MIXER;
		next_route_flags[5] = next_routing[`ORD_RDAC_HI:`ORD_RDAC_LO]
			== `ORD_ROUTE_PHONE;
		next_route_flags[6] = next_routing[`ORD_ANALOG_INPUT_TWO_RIGHT];
		next_route_flags[7] = next_routing[`ORD_DIFF];
		// Volume stage connection and driver state per channel.
		for (int i = 0; i < `ORD_CHANNELS; i++) begin
			next_volume_route[i] = next_vol[i][`ORD_VOL_ROUTE];
			next_unmute[i] = next_drv[i][`ORD_UNMUTE];
		end
		next_volume_route[`ORD_CH_SPK] =
			next_vol[`ORD_CH_SPK][`ORD_VOL_ROUTE];
		next_unmute[`ORD_CH_SPK] =
			next_drv[`ORD_CH_SPK][`ORD_UNMUTE];
		next_hiz[0] = next_drv[`ORD_CH_LP][`ORD_PD_HIZ];
		next_hiz[1] = next_drv[`ORD_CH_RP][`ORD_PD_HIZ];
	end

	// Registers for the register file and its decoded outputs.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			routing <= `ORD_RST_ROUTING;
			spk_amp <= `ORD_RST_SPK_AMP;
			vol <= {3{`ORD_RST_VOL}};
			drv <= {`ORD_RST_DRV_SPK, `ORD_RST_DRV_HP, `ORD_RST_DRV_HP};
			reg_rdata <= 8'h00;
			{left_to_right_phone, ain_two_to_right_mixer,
				right_dac_to_phone, right_dac_to_mixer,
				ain_two_to_left_mixer, ain_one_to_left_mixer,
				left_dac_to_phone, left_dac_to_mixer} <= 8'h00;
			volume_route <= 3'h0;
			driver_unmute <= 3'h0;
			phone_pd_hiz <= 2'h3;
			speaker_power_up <= 1'b0;
		end else if (clk_en) begin
			routing <= next_routing;
			spk_amp <= next_spk_amp;
			vol <= next_vol;
			drv <= next_drv;
			reg_rdata <= next_rdata;
			{left_to_right_phone, ain_two_to_right_mixer,
				right_dac_to_phone, right_dac_to_mixer,
				ain_two_to_left_mixer, ain_one_to_left_mixer,
				left_dac_to_phone, left_dac_to_mixer} <= next_route_flags;
			volume_route <= next_volume_route;
			driver_unmute <= next_unmute;
			phone_pd_hiz <= next_hiz;
			speaker_power_up <= next_spk_amp[`ORD_SPK_POWER];
		end
	end

	// Step timer: every ramp moves one code per period.
	always_comb begin
		step_tick = step_cnt == CW'(STEP_CYCLES - 1);
		next_step_cnt = step_tick ? '0 : step_cnt + 1'b1;
	end

	// Register the step timer.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			step_cnt <= '0;
		end else if (clk_en) begin
			step_cnt <= next_step_cnt;
		end
	end

	// Per-channel gain ramps and their done flags.
	for (genvar ch = 0; ch < `ORD_CHANNELS; ch++) begin : g_chan
		ord_pkg::ord_vol_t   vol_target;	// Programmed volume.
		ord_pkg::ord_gain_t  gain_target;	// Programmed driver gain.
		ord_pkg::ord_vol_t   next_av;
		ord_pkg::ord_gain_t  next_ag;
		logic                next_done;

		// Step applied values toward the newest programmed ones.
		always_comb begin
			vol_target = next_vol[ch][`ORD_VOL_HI:`ORD_VOL_LO];
			if (ch == `ORD_CH_SPK) begin
				gain_target = {2'b00,
					next_drv[ch][`ORD_SGAIN_HI:`ORD_SGAIN_LO]};
			end else if (next_drv[ch][`ORD_PGAIN_HI:`ORD_PGAIN_LO]
					> `ORD_PGAIN_MAX) begin
				gain_target = `ORD_PGAIN_MAX;
			end else begin
				gain_target = next_drv[ch][`ORD_PGAIN_HI:`ORD_PGAIN_LO];
			end
			next_av = applied_volume[ch];
			next_ag = applied_gain[ch];
			if (step_tick) begin
				if (next_av < vol_target) begin
					next_av = next_av + 1'b1;
				end else if (next_av > vol_target) begin
					next_av = next_av - 1'b1;
				end
				if (next_ag < gain_target) begin
					next_ag = next_ag + 1'b1;
				end else if (next_ag > gain_target) begin
					next_ag = next_ag - 1'b1;
				end
			end
			// Judged against the new target, so a write clears it.
			next_done = (next_av == vol_target)
				&& (next_ag == gain_target);
		end

		// Register the applied values and done flag.
		always_ff @(posedge clock or negedge reset_n) begin
			if (!reset_n) begin
				// The stored reset byte carries the route bit; keep the code.
				applied_volume[ch] <= ord_pkg::ord_vol_t'(`ORD_RST_VOL);
				applied_gain[ch] <= 4'h0;
				gain_done[ch] <= 1'b1;
			end else if (clk_en) begin
				applied_volume[ch] <= next_av;
				applied_gain[ch] <= next_ag;
				gain_done[ch] <= next_done;
			end
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	// Direct phone routing follows code 10 only.
	property p_ldac_phone;
		left_dac_to_phone == (routing[`ORD_LDAC_HI:`ORD_LDAC_LO]
			== `ORD_ROUTE_PHONE);
	endproperty
	a_ldac_phone: assert property (p_ldac_phone)
		else $error("left converter phone route wrong");

	// Mixer routing of the right converter follows code 01 only.
	property p_rdac_mixer;
		right_dac_to_mixer == (routing[`ORD_RDAC_HI:`ORD_RDAC_LO]
			== `ORD_ROUTE_MIXER);
	endproperty
	a_rdac_mixer: assert property (p_rdac_mixer)
		else $error("right converter mixer route wrong");

	// A routing write shows on the input-one-left and input-two-right routes one cycle later.
	property p_ain_route;
		clk_en && reg_write && reg_addr == `ORD_ADDR_ROUTING |=>
			ain_one_to_left_mixer == $past(reg_wdata[`ORD_ANALOG_INPUT_ONE_LEFT])
			&& ain_two_to_right_mixer
			== $past(reg_wdata[`ORD_ANALOG_INPUT_TWO_RIGHT]);
	endproperty
	a_ain_route: assert property (p_ain_route)
		else $error("input routing did not follow write");

	// Phone gain never steps above nine.
	property p_phone_gain_max;
		applied_gain[`ORD_CH_LP] <= `ORD_PGAIN_MAX
			&& applied_gain[`ORD_CH_RP] <= `ORD_PGAIN_MAX;
	endproperty
	a_phone_gain_max: assert property (p_phone_gain_max)
		else $error("phone gain beyond nine");

	// A volume write of a new code clears the done flag next cycle.
	// A step landing on the write edge may finish a one-code ramp at once,
	// so only writes that meet no step are held to this.
	property p_write_clears;
		clk_en && !step_tick && reg_write && reg_addr == `ORD_ADDR_VOL_LP
			&& reg_wdata[`ORD_VOL_HI:`ORD_VOL_LO]
			!= applied_volume[`ORD_CH_LP] |=> !gain_done[`ORD_CH_LP];
	endproperty
	a_write_clears: assert property (p_write_clears)
		else $error("done flag survived new volume");

	// Done means the applied speaker volume matches the register.
	property p_spk_done;
		gain_done[`ORD_CH_SPK] |-> applied_volume[`ORD_CH_SPK]
			== vol[`ORD_CH_SPK][`ORD_VOL_HI:`ORD_VOL_LO];
	endproperty
	a_spk_done: assert property (p_spk_done)
		else $error("speaker done with volume pending");

	// Ramps move at most one code per enabled cycle.
	property p_one_step;
		clk_en |=> applied_volume[`ORD_CH_RP]
			- $past(applied_volume[`ORD_CH_RP]) inside {7'h00, 7'h01, 7'h7f};
	endproperty
	a_one_step: assert property (p_one_step)
		else $error("volume jumped more than one step");

	// Mute, high-impedance and power state track the registers.
	property p_driver_state;
		driver_unmute[`ORD_CH_LP] == drv[`ORD_CH_LP][`ORD_UNMUTE]
			&& phone_pd_hiz[1] == drv[`ORD_CH_RP][`ORD_PD_HIZ]
			&& speaker_power_up == spk_amp[`ORD_SPK_POWER];
	endproperty
	a_driver_state: assert property (p_driver_state)
		else $error("driver state does not match registers");
endmodule // ord_output_routing_driver_regs

// ---- test_output_routing_driver_regs.sv ----
// Self-checking bench for the output routing and driver register bank.
`timescale 1ns/10ps

module test_output_routing_driver_regs;
	localparam int STEP = 2;	// Short gain step keeps every ramp brief.
	logic                     clock;	// Bench clock, 125 MHz.
	logic                     reset_n;	// Active-low reset.
	logic                     clk_en;	// Clock enable.
	logic                     reg_write;	// Write strobe.
	logic [6:0]               reg_addr;	// Register offset.
	ord_pkg::ord_byte_t       reg_wdata;	// Write data.
	ord_pkg::ord_byte_t       reg_rdata;	// Read data.
	logic [7:0]               route;	// Decoded routing flags, D7 order.
	logic [2:0]               volume_route;	// Volume stage links.
	ord_pkg::ord_vol_t [2:0]  applied_volume;	// Applied volume codes.
	ord_pkg::ord_gain_t [2:0] applied_gain;	// Applied driver gains.
	logic [2:0]               driver_unmute;	// Unmute levels.
	logic [1:0]               phone_pd_hiz;	// Power-down states.
	logic                     speaker_power_up;	// Speaker power level.
	logic [2:0]               gain_done;	// Gain-applied flags.
	logic [7:0]               mem [0:127];	// Model image of the registers.
	int                       bad_count;	// Mismatches seen.
	int                       check_count;	// Comparisons made.
	int                       seed;	// Seed of the random stream.

	// The block under test, with a short gain step.
	ord_output_routing_driver_regs #(.STEP_CYCLES(STEP)) dut (
		.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
		.reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .left_dac_to_mixer(route[7]),
		.left_dac_to_phone(route[6]), .ain_one_to_left_mixer(route[5]),
		.ain_two_to_left_mixer(route[4]), .right_dac_to_mixer(route[3]),
		.right_dac_to_phone(route[2]), .ain_two_to_right_mixer(route[1]),
		.left_to_right_phone(route[0]), .volume_route(volume_route),
		.applied_volume(applied_volume), .applied_gain(applied_gain),
		.driver_unmute(driver_unmute), .phone_pd_hiz(phone_pd_hiz),
		.speaker_power_up(speaker_power_up), .gain_done(gain_done));

	// The clock toggles every half period of 4 ns.
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// Prints the verdict and ends the run.
	task automatic final_report();
		if (bad_count == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Compares one value and reports a mismatch at once.
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", n, e, g);
			bad_count++;
		end
	endtask

	// Loads the model with the reset image of every register.
	task automatic model_reset();
		foreach (mem[k]) mem[k] = 8'h00;
		mem[7'h20] = 8'h06;
		mem[7'h24] = 8'h7f;
		mem[7'h25] = 8'h7f;
		mem[7'h26] = 8'h7f;
		mem[7'h27] = 8'h7f;
		mem[7'h28] = 8'h02;
		mem[7'h29] = 8'h02;
	endtask

	// Holds reset for two cycles, then releases it just after an edge.
	task automatic do_reset();
		reset_n = 1'b0;
		repeat (2) @(posedge clock);
		chk("rdata_in_reset", 8'h00, reg_rdata);
		#1;
		reset_n = 1'b1;
		model_reset();
	endtask

	// Target driver gain of a channel; phone codes above nine apply as nine.
	function automatic int tgt_gain(input int ch);
		logic [3:0] g;
		if (ch == 2) return int'(mem[7'h2a][4:3]);
		g = mem[7'h28 + ch][6:3];
		return (g > 4'h9) ? 9 : int'(g);
	endfunction

	// Read value: the status bit of a settled driver register is one.
	function automatic logic [7:0] exp_rd(input int a);
		if (a >= 8'h28 && a <= 8'h2a) return mem[a] | 8'h01;
		return mem[a];
	endfunction

	// One write; the strobe stays up so a further write may follow at once.
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		reg_write = 1'b1;
		reg_addr  = a;
		reg_wdata = d;
		@(posedge clock);
		#1;
		if (clk_en && (a == 7'h20 || (a >= 7'h23 && a <= 7'h26) ||
			(a >= 7'h28 && a <= 7'h2a))) begin
			mem[a] = (a == 7'h20 || a >= 7'h28) ? (d & 8'hfe) : d;
		end
	endtask

	// One read, answered by the same edge that samples the address.
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		reg_write = 1'b0;
		reg_addr  = a;
		@(posedge clock);
		#1;
		chk("read_back", e, reg_rdata);
	endtask

	// Waits a bounded time for every gain flag to come up.
	task automatic settle(input int bound);
		int n;
		n = 0;
		reg_write = 1'b0;
		do begin
			@(posedge clock);
			#1;
			n++;
		end while (gain_done !== 3'b111 && n < bound);
		chk("ramp_finished", 8'h07, {5'h0, gain_done});
		if (gain_done !== 3'b111) final_report();
	endtask

	// Routing flags decoded from the model's routing byte.
	task automatic chk_route();
		logic [7:0] r;
		r = mem[7'h23];
		chk("routing", {r[7:6] == 2'b01, r[7:6] == 2'b10, r[5], r[4],
			r[3:2] == 2'b01, r[3:2] == 2'b10, r[1], r[0]}, route);
	endtask

	// Compares every output and every register with the model.
	task automatic check_outs();
		chk_route();
		chk("power_states", {5'h0, mem[7'h29][1], mem[7'h28][1], mem[7'h20][7]},
			{5'h0, phone_pd_hiz, speaker_power_up});
		for (int i = 0; i < 3; i++) begin
			chk("volume", {1'b0, mem[7'h24 + i][6:0]}, {1'b0, applied_volume[i]});
			chk("gain", 8'(tgt_gain(i)), {4'h0, applied_gain[i]});
			chk("links", {6'h0, mem[7'h24 + i][7], mem[7'h28 + i][2]},
				{6'h0, volume_route[i], driver_unmute[i]});
		end
		for (int a = 8'h20; a <= 8'h2b; a++) rd(7'(a), exp_rd(a));
		rd(7'h10, 8'h00);
	endtask

	// A gain write: the flag drops for a change of more than one code, then the ramp ends within its bound.
	task automatic gain_write(input int ch, input logic [6:0] a, input logic [7:0] d);
		int ov, og, dl;
		ov = int'(mem[7'h24 + ch][6:0]);
		og = tgt_gain(ch);
		wr(a, d);
		ov = ov - int'(mem[7'h24 + ch][6:0]);
		og = og - tgt_gain(ch);
		ov = (ov < 0) ? -ov : ov;
		og = (og < 0) ? -og : og;
		dl = (ov > og) ? ov : og;
		if (dl > 1) chk("done_drops", 8'h00, {7'h0, gain_done[ch]});
		settle(dl * STEP + 3);
		check_outs();
	endtask

	// Main sequence.
	initial begin
		logic [7:0] d;
		int         ch;
		seed        = 32'hf930;
		bad_count   = 0;
		check_count = 0;
		clk_en      = 1'b1;
		reg_write   = 1'b0;
		reg_addr    = 7'h00;
		reg_wdata   = 8'h00;
		do_reset();
		check_outs();
		// Every routing code, reserved ones too, with random companion bits.
		for (int i = 0; i < 16; i++) begin
			d = 8'($random(seed));
			wr(7'h23, {i[1:0], d[5:4], i[3:2], d[1:0]});
			chk_route();
		end
		// Speaker power up; the status bit cannot be written.
		wr(7'h20, 8'h87);
		wr(7'h10, 8'h5a);
		check_outs();
		// Full-scale volume ramp, then a clamped gain written back to back.
		gain_write(0, 7'h24, 8'h80);
		wr(7'h25, 8'h80);
		wr(7'h21, 8'h00);
		wr(7'h29, 8'h7c);
		settle(127 * STEP + 3);
		check_outs();
		// Random targets on every channel, reserved bits kept zero.
		for (int i = 0; i < 24; i++) begin
			ch = i % 3;
			d  = 8'($random(seed));
			if (d[0]) begin
				d = 8'($random(seed));
				// Weak common mode asks for the pop-removal bit to be cleared.
				if (ch < 2 && !d[1]) wr(7'h21, 8'h00);
				gain_write(ch, 7'(8'h28 + ch), d & ((ch < 2) ? 8'h7e : 8'h1c));
			end else begin
				gain_write(ch, 7'(8'h24 + ch), 8'($random(seed)));
			end
		end
		// A write while the clock enable is low leaves everything alone.
		clk_en = 1'b0;
		wr(7'h23, 8'hff);
		clk_en = 1'b1;
		check_outs();
		// A second reset in mid-run restores the reset image.
		do_reset();
		check_outs();
		final_report();
	end
endmodule // test_output_routing_driver_regs
